// ==== rtl/dcbd_pkg.sv ====
// Shared constants, state codes and helpers for the balanced link ends
package dcbd_pkg;
  localparam int DCBD_LANES = 3;
  localparam int DCBD_DATA_BITS = 7;
  localparam int DCBD_WORD_W = 21;
  localparam int DCBD_CLK_MHZ = 100;
  // Word lengths per mode, idle index and balance flag positions
  localparam logic [3:0] DCBD_NBITS_DCB = 4'h9;
  localparam logic [3:0] DCBD_NBITS_NDC = 4'h7;
  localparam logic [3:0] DCBD_IDX_IDLE = 4'hf;
  localparam int DCBD_FLAG_INV_POS = 7;
  localparam int DCBD_FLAG_CMP_POS = 8;
  // Link clock high time, in bits of the word
  localparam logic [3:0] DCBD_HI_SHORT = 4'h4;
  localparam logic [3:0] DCBD_HI_LONG = 4'h5;
  localparam logic [3:0] DCBD_HI_NDC = 4'h4;
  // Serial bit timing in core clock cycles
  localparam int DCBD_BIT_CYC = 4;
  localparam int DCBD_SAMPLE_OFS = 2;
  // Lock and clock-loss timing, and FIFO depth
  localparam int DCBD_LOCK_PERIODS = 32800;
  localparam int DCBD_LOSS_TIME_NS = 1000;
  localparam int DCBD_LOSS_CYC = DCBD_LOSS_TIME_NS * DCBD_CLK_MHZ / 1000;
  localparam int DCBD_FIFO_DEPTH = 16;
  // Positions in the synchroniser vector
  localparam int DCBD_SY_CLK = 0;
  localparam int DCBD_SY_LANE0 = 1;
  localparam int DCBD_SY_MODE = 4;
  localparam int DCBD_SY_PDN = 5;
  localparam int DCBD_SY_W = 6;

  typedef enum logic [2:0] {
    DCBD_ST_PDN = 3'b001,
    DCBD_ST_LOCKING = 3'b010,
    DCBD_ST_LOCKED = 3'b100
  } dcbd_lock_e;

  // Reverse the low n bits of a serial word
  function automatic logic [8:0] dcbd_rev(input logic [8:0] x, input logic [3:0] n);
    logic [8:0] r;
    r = '0;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(n)) begin
        r[int'(n) - 1 - i] = x[i];
      end
    end
    return r;
  endfunction
endpackage

// ==== rtl/dcbd_link_if.sv ====
// Link wires between the serializer end and the deserializer end
`timescale 1ns/1ps
`default_nettype none
interface dcbd_link_if;
  logic link_clock_in;
  logic [2:0] serial_lane_in;
  modport ser (output link_clock_in, output serial_lane_in);
  modport des (input link_clock_in, input serial_lane_in);
endinterface // dcbd_link_if
`default_nettype wire

// ==== rtl/dcbd_serializer.sv ====
// Serializer end: input FIFO, balance coding and link clock generation
`timescale 1ns/1ps
`default_nettype none
module dcbd_fifo #(
  parameter int W = 21,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] cnt_r;
  wire logic push = in_valid & in_ready;
  wire logic pop = out_valid & out_ready;
  wire logic [CW-1:0] cnt_nxt = cnt_r + CW'(push) - CW'(pop);
  wire logic [AW-1:0] wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
  wire logic [AW-1:0] rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
  assign out_data = mem_r[rd_ptr_r];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_ptr_r <= push ? wr_ptr_nxt : wr_ptr_r;
      rd_ptr_r <= pop ? rd_ptr_nxt : rd_ptr_r;
      cnt_r <= cnt_nxt;
      in_ready <= cnt_nxt != CW'(DEPTH);
      out_valid <= cnt_nxt != '0;
    end
  end
endmodule // dcbd_fifo

module dcbd_serializer
  import dcbd_pkg::*;
#(
  parameter int BIT_CYC = DCBD_BIT_CYC,
  parameter bit LSB_FIRST = 1'b1,
  parameter int FIFO_DEPTH = DCBD_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic balance_mode_select,
  input wire logic [DCBD_WORD_W-1:0] word_in,
  input wire logic word_valid,
  output logic word_ready,
  dcbd_link_if.ser link
);
  localparam int DW = $clog2(BIT_CYC + 1);
  logic [DW-1:0] div_r;
  logic [3:0] idx_r;
  logic mode_r;
  logic alt_r;
  logic clk_r;
  logic [DCBD_LANES-1:0] lane_r;
  logic [DCBD_WORD_W-1:0] fifo_data;
  logic fifo_valid;
  wire logic [DCBD_LANES-1:0] first_bit;
  wire logic [DCBD_LANES-1:0] next_bit;

  // Bit-rate enable and word boundary
  wire logic bit_en = div_r == DW'(BIT_CYC - 1);
  wire logic [3:0] nb = mode_r ? DCBD_NBITS_DCB : DCBD_NBITS_NDC;
  wire logic load = bit_en & (idx_r == nb - 4'h1);
  wire logic mode_eff = load ? balance_mode_select : mode_r;
  wire logic alt_eff = load ? ~alt_r : alt_r;
  wire logic [3:0] nb_eff = mode_eff ? DCBD_NBITS_DCB : DCBD_NBITS_NDC;
  wire logic [3:0] idx_nxt = load ? 4'h0 : idx_r + 4'h1;
  wire logic [3:0] hi = mode_eff ? (alt_eff ? DCBD_HI_LONG : DCBD_HI_SHORT) : DCBD_HI_NDC; // RQ7

  // The FIFO drains one word per link period, so a fast source stalls
  dcbd_fifo #(.W(DCBD_WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_data(word_in),
    .in_valid(word_valid),
    .in_ready(word_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(load)
  );

  for (genvar g = 0; g < DCBD_LANES; g++) begin : g_lane
    logic [8:0] sh_r;
    logic signed [5:0] rds_r;
    // Empty FIFO sends an all-zero payload
    wire logic [6:0] p = fifo_valid ? fifo_data[g*DCBD_DATA_BITS +: DCBD_DATA_BITS] : '0;
    wire logic [2:0] ones = 3'(p[0] + p[1] + p[2] + p[3] + p[4] + p[5] + p[6]);
    wire logic signed [5:0] disp = $signed({2'b00, ones, 1'b0}) - 6'sh07;
    wire logic pos = ~ones[2] ? 1'b0 : 1'b1;
    wire logic inv = mode_eff & ((rds_r >= 0) ? pos : ~pos); // RQ5
    wire logic [8:0] enc = {~inv, inv, p ^ {7{inv}}}; // RQ4
    wire logic [8:0] ord = LSB_FIRST ? enc : dcbd_rev(enc, nb_eff); // RQ17
    assign first_bit[g] = ord[0];
    assign next_bit[g] = sh_r[0];

    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        sh_r <= '0;
        rds_r <= '0;
      end else if (load) begin
        sh_r <= ord >> 1;
        rds_r <= !mode_eff ? 6'sh00 : (inv ? rds_r - disp : rds_r + disp); // RQ8
      end else if (bit_en) begin
        sh_r <= sh_r >> 1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      div_r <= '0;
      idx_r <= DCBD_NBITS_NDC - 4'h1;
      mode_r <= 1'b0;
      alt_r <= 1'b0;
      clk_r <= 1'b0;
      lane_r <= '0;
    end else begin
      div_r <= bit_en ? '0 : div_r + 1'b1;
      if (bit_en) begin
        idx_r <= idx_nxt;
        mode_r <= mode_eff;
        alt_r <= mode_eff & alt_eff;
        clk_r <= idx_nxt < hi; // RQ9
        lane_r <= load ? first_bit : next_bit;
      end
    end
  end

  assign link.link_clock_in = clk_r;
  assign link.serial_lane_in = lane_r;
endmodule // dcbd_serializer
`default_nettype wire

// ==== rtl/dcbd_deserializer.sv ====
// Deserializer end: lane sampling, balance decode, lock and output control
// Operation
// RQ1 - Select high picks balanced, low non-balanced
// RQ2 - Non-balanced: seven data bits per lane
// RQ3 - Balanced: nine bits, seven data two flags
// RQ4 - Serializer appends two complementary inversion flags
// RQ5 - Serializer inverts by running sum sign
// RQ6 - Flagged groups are inverted back
// RQ7 - Balanced link clock alternates four/five ninths high
// RQ8 - Data lane running sum within ten
// RQ9 - Clock lane running sum within five
// RQ10 - Low-speed variant link clock frequency ranges
// RQ11 - High-speed variant link clock frequency ranges
// RQ12 - Recovered clock out, rising or falling strobe
// RQ13 - Power-down floats outputs; wake drives them low
// RQ14 - Lock by counter, outputs low meanwhile
// RQ15 - Lost or slow link clock forces outputs low
// RQ16 - Lanes map to bits 0-6, 7-13, 14-20
// RQ17 - Bit order and word phase are parameters
`timescale 1ns/1ps
`default_nettype none
module dcbd_deserializer
  import dcbd_pkg::*;
#(
  parameter int BIT_CYC = DCBD_BIT_CYC,
  parameter int SAMPLE_OFS = DCBD_SAMPLE_OFS,
  parameter bit LSB_FIRST = 1'b1,
  parameter bit FALLING_STROBE = 1'b0,
  parameter int LOCK_PERIODS = DCBD_LOCK_PERIODS,
  parameter int LOSS_CYC = DCBD_LOSS_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic balance_mode_select,
  input wire logic power_down_n,
  dcbd_link_if.des link,
  output logic [DCBD_WORD_W-1:0] parallel_word_out,
  output logic parallel_word_oe_n,
  output logic recovered_clock_out,
  output logic recovered_clock_oe_n,
  output logic lock_status
);
  localparam int PW = $clog2(BIT_CYC + 1);
  localparam int LW = $clog2(LOCK_PERIODS + 1);
  localparam int IW = $clog2(LOSS_CYC + 1);

  // Synchroniser stages; s1_r feeds s2_r only
  logic [DCBD_SY_W-1:0] s1_r;
  logic [DCBD_SY_W-1:0] s2_r;
  logic [DCBD_SY_W-1:0] s3_r;
  logic [DCBD_SY_W-1:0] filt_r;
  logic clk_d_r;
  logic mode_d_r;

  // Word framing
  logic [PW-1:0] ph_r;
  logic [3:0] idx_r;

  // Lock tracking
  dcbd_lock_e st_r;
  dcbd_lock_e st_nxt;
  logic [LW-1:0] lock_cnt_r;
  logic [IW-1:0] idle_cnt_r;

  wire logic [DCBD_WORD_W-1:0] word_dec;

  wire logic [DCBD_SY_W-1:0] raw_in = {power_down_n, balance_mode_select,
                                       link.serial_lane_in, link.link_clock_in};
  // A change counts only once two later stages agree
  wire logic [DCBD_SY_W-1:0] agree = s2_r ~^ s3_r;
  wire logic [DCBD_SY_W-1:0] filt_nxt = (agree & s3_r) | (~agree & filt_r);

  wire logic lclk = filt_r[DCBD_SY_CLK];
  wire logic pdn_ok = filt_r[DCBD_SY_PDN];
  wire logic dcb = filt_r[DCBD_SY_MODE]; // RQ1
  wire logic running = st_r != DCBD_ST_PDN;
  wire logic rise = running & lclk & ~clk_d_r;
  wire logic fall = running & ~lclk & clk_d_r;
  wire logic strobe = FALLING_STROBE ? fall : rise; // RQ12
  wire logic mode_chg = dcb != mode_d_r;
  wire logic clk_lost = idle_cnt_r == IW'(LOSS_CYC); // RQ15
  wire logic locked = st_r == DCBD_ST_LOCKED;
  wire logic lock_done = lock_cnt_r == LW'(LOCK_PERIODS - 1);

  // Bits per word follow the mode
  wire logic [3:0] nbits = dcb ? DCBD_NBITS_DCB : DCBD_NBITS_NDC; // RQ2 RQ3
  wire logic in_word = idx_r < nbits;
  wire logic sample = running & ~rise & in_word & (ph_r == PW'(SAMPLE_OFS));
  wire logic last = sample & (idx_r == nbits - 4'h1);
  wire logic ph_wrap = ph_r == PW'(BIT_CYC - 1);
  wire logic [3:0] idx_step = (idx_r == nbits - 4'h1) ? DCBD_IDX_IDLE : idx_r + 4'h1;
  // Sample position inside the word
  wire logic [3:0] pos = LSB_FIRST ? idx_r : nbits - 4'h1 - idx_r; // RQ17
  wire logic [8:0] pos_mask = 9'h001 << pos;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      filt_r <= '0;
      clk_d_r <= 1'b0;
      mode_d_r <= 1'b0;
    end else begin
      s1_r <= raw_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
      clk_d_r <= lclk;
      mode_d_r <= dcb;
    end
  end

  // Framing restarts at each link clock rise; idle index stops sampling
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ph_r <= '0;
      idx_r <= DCBD_IDX_IDLE;
    end else if (!running) begin // RQ13
      ph_r <= '0;
      idx_r <= DCBD_IDX_IDLE;
    end else if (rise) begin // RQ17
      ph_r <= PW'(1);
      idx_r <= 4'h0;
    end else if (in_word) begin
      ph_r <= ph_wrap ? '0 : ph_r + 1'b1;
      idx_r <= ph_wrap ? idx_step : idx_r;
    end
  end

  for (genvar g = 0; g < DCBD_LANES; g++) begin : g_lane
    logic [8:0] acc_r;
    logic [8:0] hold_r;
    wire logic din = filt_r[DCBD_SY_LANE0 + g];
    wire logic [8:0] acc_set = din ? (acc_r | pos_mask) : (acc_r & ~pos_mask);
    // Clearing at the rise keeps stale flags out of a seven-bit word
    wire logic [8:0] acc_nxt = rise ? '0 : (sample ? acc_set : acc_r);
    // Flags must be complementary to count as inverted
    wire logic inv = dcb & hold_r[DCBD_FLAG_INV_POS] & ~hold_r[DCBD_FLAG_CMP_POS]; // RQ6
    assign word_dec[g*DCBD_DATA_BITS +: DCBD_DATA_BITS] =
      hold_r[DCBD_DATA_BITS-1:0] ^ {DCBD_DATA_BITS{inv}}; // RQ16

    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        acc_r <= '0;
        hold_r <= '0;
      end else begin
        acc_r <= acc_nxt;
        hold_r <= last ? acc_nxt : hold_r;
      end
    end
  end

  // Lock state
  always_comb begin
    case (st_r)
      DCBD_ST_PDN: begin
        st_nxt = pdn_ok ? DCBD_ST_LOCKING : DCBD_ST_PDN;
      end
      DCBD_ST_LOCKING: begin
        if (!pdn_ok) begin
          st_nxt = DCBD_ST_PDN;
        end else if (rise & lock_done & ~clk_lost & ~mode_chg) begin
          st_nxt = DCBD_ST_LOCKED; // RQ14
        end else begin
          st_nxt = DCBD_ST_LOCKING;
        end
      end
      DCBD_ST_LOCKED: begin
        if (!pdn_ok) begin
          st_nxt = DCBD_ST_PDN;
        end else if (clk_lost | mode_chg) begin
          st_nxt = DCBD_ST_LOCKING; // RQ15
        end else begin
          st_nxt = DCBD_ST_LOCKED;
        end
      end
      default: begin
        st_nxt = DCBD_ST_PDN;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= DCBD_ST_PDN;
      lock_cnt_r <= '0;
      idle_cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      // Idle counter saturates so a dead clock stays flagged
      if (rise | fall | !running) begin
        idle_cnt_r <= '0;
      end else if (!clk_lost) begin
        idle_cnt_r <= idle_cnt_r + 1'b1;
      end
      if (st_r != DCBD_ST_LOCKING || clk_lost || mode_chg) begin
        lock_cnt_r <= '0;
      end else if (rise && !lock_done) begin
        lock_cnt_r <= lock_cnt_r + 1'b1; // RQ14
      end
    end
  end

  // Outputs float in power-down and are held low until locked
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      parallel_word_out <= '0;
      parallel_word_oe_n <= 1'b1;
      recovered_clock_out <= 1'b0;
      recovered_clock_oe_n <= 1'b1;
      lock_status <= 1'b0;
    end else begin
      parallel_word_oe_n <= st_r == DCBD_ST_PDN; // RQ13
      recovered_clock_oe_n <= st_r == DCBD_ST_PDN;
      lock_status <= locked;
      recovered_clock_out <= locked & lclk; // RQ12
      if (!locked) begin
        parallel_word_out <= '0; // RQ14 RQ15
      end else if (strobe) begin
        parallel_word_out <= word_dec;
      end
    end
  end
endmodule // dcbd_deserializer
`default_nettype wire

// ==== bench/dcbd_link_chk.sv ====
// Wire-level checks on the link between the serializer and deserializer ends
`timescale 1ns/1ps
`default_nettype none
module dcbd_link_chk
  import dcbd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic balance_mode_select,
  input wire logic link_clock_in,
  input wire logic [2:0] serial_lane_in
);
  localparam int BC = DCBD_BIT_CYC;
  logic clk_d_r;
  logic seen_r;
  logic [7:0] pos_r;
  logic [7:0] last_hi_r;
  logic [2:0] flag_r;
  wire logic rise_w = link_clock_in & ~clk_d_r;
  wire logic fall_w = ~link_clock_in & clk_d_r;
  wire logic bal_w = balance_mode_select;
  wire logic at_flag_w = (pos_r == 8'(7 * BC + BC / 2));
  wire logic at_cmp_w = (pos_r == 8'(8 * BC + BC / 2));
  // Cycles since the last link clock rise; a whole period reads as its length
  always_ff @(posedge mclk) begin
    clk_d_r <= rst_n & link_clock_in;
    pos_r <= !rst_n ? 8'h00 : (rise_w ? 8'h01 : pos_r + 8'h01);
    seen_r <= rst_n & (seen_r | rise_w);
  end
  always_ff @(posedge mclk) begin
    last_hi_r <= !rst_n ? 8'h00 : (fall_w ? pos_r : last_hi_r);
    flag_r <= at_flag_w ? serial_lane_in : flag_r;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_HI_BAL: assert property (bal_w && fall_w |-> pos_r == 8'(4 * BC) || pos_r == 8'(5 * BC))
    else $error("balanced link clock high time is not four or five bits");
  AST_HI_ALT: assert property (bal_w && fall_w && last_hi_r != 8'h00 |-> pos_r != last_hi_r)
    else $error("balanced link clock high time does not alternate");
  AST_PER_BAL: assert property (bal_w && seen_r && rise_w |-> pos_r == 8'(9 * BC))
    else $error("balanced link period is not nine bits");
  AST_PER_NDC: assert property (!bal_w && seen_r && rise_w |-> pos_r == 8'(7 * BC))
    else $error("non-balanced link period is not seven bits");
  AST_HI_NDC: assert property (!bal_w && fall_w |-> pos_r == 8'(4 * BC))
    else $error("non-balanced link clock high time is wrong");
  AST_FLAGS: assert property (bal_w && seen_r && at_cmp_w |-> serial_lane_in == ~flag_r)
    else $error("balance flag bits are not complementary");
  AST_BIT_HOLD: assert property (seen_r && (pos_r % BC) != 0 |-> $stable(serial_lane_in))
    else $error("lane changed inside a bit time");
  AST_EDGE_ALIGN: assert property (seen_r && $changed(link_clock_in) |-> (pos_r % BC) == 0)
    else $error("link clock edge off a bit boundary");
  cover property (bal_w && seen_r && rise_w);
  cover property (!bal_w && seen_r && rise_w);
  cover property (bal_w && at_cmp_w && flag_r != 3'h0);
endmodule // dcbd_link_chk
`default_nettype wire

// ==== bench/test_dc_balance_lvds_deserializer.sv ====
// Testbench: both link ends back to back, plus a deserializer on a faulty link
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module test_dc_balance_lvds_deserializer;
  import dcbd_pkg::*;
  localparam int LOCKN = 8;
  logic mclk, rst_n, mode, pdn, word_valid, refused, long_hi;
  logic [20:0] word_in;
  wire logic word_ready, oe_n, rclk, rclk_oe_n, lock, oe_b, lock_b;
  wire logic [20:0] pw, pw_b;
  int n_errors = 0;
  int checks_done = 0;
  dcbd_link_if dcbd_link_if_inst();
  dcbd_link_if fault_link();
  dcbd_serializer dcbd_serializer_inst (.mclk(mclk), .rst_n(rst_n),
    .balance_mode_select(mode), .word_in(word_in), .word_valid(word_valid),
    .word_ready(word_ready), .link(dcbd_link_if_inst.ser));
  dcbd_deserializer #(.LOCK_PERIODS(LOCKN)) dcbd_deserializer_inst (.mclk(mclk),
    .rst_n(rst_n), .balance_mode_select(mode), .power_down_n(pdn),
    .link(dcbd_link_if_inst.des), .parallel_word_out(pw), .parallel_word_oe_n(oe_n),
    .recovered_clock_out(rclk), .recovered_clock_oe_n(rclk_oe_n), .lock_status(lock));
  dcbd_deserializer #(.LOCK_PERIODS(LOCKN)) dcbd_deserializer_b_inst (.mclk(mclk),
    .rst_n(rst_n), .balance_mode_select(1'b1), .power_down_n(pdn),
    .link(fault_link.des), .parallel_word_out(pw_b), .parallel_word_oe_n(oe_b),
    .recovered_clock_out(), .recovered_clock_oe_n(), .lock_status(lock_b));
  dcbd_link_chk dcbd_link_chk_inst (.mclk(mclk), .rst_n(rst_n), .balance_mode_select(mode),
    .link_clock_in(dcbd_link_if_inst.link_clock_in),
    .serial_lane_in(dcbd_link_if_inst.serial_lane_in));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic tally_and_finish;
    if (n_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Lanes 0..2 each fully set first, then an all-ones word, sent inverted only in balanced mode when the running sum is not negative
  function automatic logic [20:0] word_of(input int i);
    case (i)
      0: return 21'h00007f;
      1: return 21'h003f80;
      2: return 21'h1fc000;
      3: return 21'h1fffff;
      default: return 21'(i * 32'h00012345) ^ 21'h155555;
    endcase
  endfunction
  // Request held until an edge that sees ready high
  task automatic put_word(input logic [20:0] w);
    int t;
    t = 0;
    word_in = w;
    word_valid = 1'b1;
    do begin
      @(posedge mclk);
      t++;
      if (word_ready !== 1'b1) refused = 1'b1;
    end while (word_ready !== 1'b1 && t < 2000);
    if (t >= 2000) begin
      n_errors++;
      tally_and_finish();
    end
    @(negedge mclk);
  endtask
  task automatic get_word(input logic [20:0] exp);
    int t;
    logic [20:0] prev;
    t = 0;
    prev = pw;
    while (pw === prev && t < 400) begin
      cyc(1);
      t++;
    end
    // A word that never arrives ends the run as a failure
    if (t >= 400) begin
      n_errors++;
      tally_and_finish();
    end
    `CHK(pw, exp)
    cyc(2);
    `CHK(rclk, 1'b1)
  endtask
  task automatic run_stream(input int n);
    fork
      begin
        for (int i = 0; i < n; i++) put_word(word_of(i));
        word_valid = 1'b0;
      end
      for (int j = 0; j < n; j++) get_word(word_of(j));
    join
  endtask
  task automatic wait_lock;
    int t;
    t = 0;
    while (lock !== 1'b1 && t < 3000) begin
      cyc(1);
      t++;
    end
    if (t >= 3000) begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  // Faulty-side driver: LSB first, flags {inv, ~inv}, high time alternating 4 and 5 bits
  task automatic frame(input logic [20:0] w, input logic [2:0] inv);
    for (int k = 0; k < 9; k++) begin
      for (int g = 0; g < 3; g++) begin
        fault_link.serial_lane_in[g] = (k < 7) ? w[7 * g + k] ^ inv[g] : ((k == 7) ? inv[g] : ~inv[g]);
      end
      fault_link.link_clock_in = (k < (long_hi ? 5 : 4));
      cyc(DCBD_BIT_CYC);
    end
    long_hi = ~long_hi;
  endtask
  initial begin
    rst_n = 1'b0;
    mode = 1'b1;
    pdn = 1'b0;
    word_in = 21'h000000;
    word_valid = 1'b0;
    refused = 1'b0;
    long_hi = 1'b0;
    fault_link.link_clock_in = 1'b0;
    fault_link.serial_lane_in = 3'h0;
    cyc(3);
    rst_n = 1'b1;
    cyc(8);
    `CHK(oe_n, 1'b1)
    `CHK(rclk_oe_n, 1'b1)
    pdn = 1'b1;
    cyc(10);
    `CHK(oe_n, 1'b0)
    `CHK(pw, 21'h000000)
    `CHK(lock, 1'b0)
    `CHK(rclk, 1'b0)
    wait_lock();
    `CHK(lock, 1'b1)
    run_stream(20);
    `CHK(refused, 1'b1)
    `CHK(word_ready, 1'b1)
    `CHK(rclk_oe_n, 1'b0)
    rst_n = 1'b0;
    mode = 1'b0;
    cyc(3);
    rst_n = 1'b1;
    cyc(10);
    wait_lock();
    run_stream(6);
    pdn = 1'b0;
    cyc(12);
    `CHK(oe_n, 1'b1)
    `CHK(lock, 1'b0)
    pdn = 1'b1;
    cyc(10);
    repeat (LOCKN + 4) frame(21'h1a2b3c, 3'h0);
    `CHK(lock_b, 1'b1)
    `CHK(pw_b, 21'h1a2b3c)
    repeat (2) frame(21'h0f0f0f, 3'h5);
    `CHK(pw_b, 21'h0f0f0f)
    // Link clock stops; lanes keep moving so stale values cannot pass
    fault_link.link_clock_in = 1'b0;
    repeat (120) begin
      fault_link.serial_lane_in = ~fault_link.serial_lane_in;
      cyc(1);
    end
    `CHK(lock_b, 1'b0)
    `CHK(pw_b, 21'h000000)
    `CHK(oe_b, 1'b0)
    tally_and_finish();
  end
endmodule // test_dc_balance_lvds_deserializer
`default_nettype wire
